// ===== shared/call_cmp_map.vh
// Purpose: field positions, opcodes and constants for the call/compare unit
// Assumes: 32-bit instruction words, 32 registers
// Notes:   definitions only
`ifndef CALL_CMP_MAP_VH
`define CALL_CMP_MAP_VH

`define OP_MAJOR_HI     5
`define OP_MAJOR_LO     0
`define OPX_HI          16
`define OPX_LO          11
`define IMM5_HI         10
`define IMM5_LO         6
`define SRC_A_HI        31
`define SRC_A_LO        27
`define SRC_B_HI        26
`define SRC_B_LO        22
`define DEST_HI         21
`define DEST_LO         17
`define WIDX_HI         31
`define WIDX_LO         6
`define PC_REGION_HI    31
`define PC_REGION_LO    28

`define OP_RTYPE        6'h3A
`define OP_CALL_IMM     6'h00
`define OPX_CALL_REG    6'h1D
`define OPX_CMP_EQ      6'h20
`define LINK_REG_IDX    5'h1F
`define ZERO_REG_IDX    5'h00
`define NEXT_PC_STEP    32'h00000004
`define PC_RESET_VALUE  32'h00000000

`endif

// ===== rtl/call_cmp_decode.v
// Purpose: decode of the immediate call, register call and equality compare
// Assumes: instruction word stable while valid
// Notes:   purely combinational
`timescale 1ns/1ps
`include "call_cmp_map.vh"

module call_cmp_decode (
    // instruction
    input  wire [31:0] instr,
    // decoded class
    output wire        isCallImm,
    output wire        isCallReg,
    output wire        isCmpEq
);
    wire [5:0] opMajor = instr[`OP_MAJOR_HI:`OP_MAJOR_LO];
    wire [5:0] opExt   = instr[`OPX_HI:`OPX_LO];
    wire [4:0] imm5    = instr[`IMM5_HI:`IMM5_LO];
    wire [4:0] srcB    = instr[`SRC_B_HI:`SRC_B_LO];
    wire [4:0] dest    = instr[`DEST_HI:`DEST_LO];
    wire       rType   = (opMajor == `OP_RTYPE);

    assign isCallImm = (opMajor == `OP_CALL_IMM);
    assign isCallReg = rType && (opExt == `OPX_CALL_REG)
                       && (srcB == `ZERO_REG_IDX)
                       && (dest == `LINK_REG_IDX)
                       && (imm5 == 5'h00);
    assign isCmpEq   = rType && (opExt == `OPX_CMP_EQ)
                       && (imm5 == 5'h00);
endmodule

// ===== rtl/call_and_equality_exec.v
// Purpose: execute stage for immediate call, register call and equality compare
// Assumes: operand values come from the register file on the same clock
// Notes:   one instruction per valid cycle; results registered one cycle later
`timescale 1ns/1ps
`include "call_cmp_map.vh"

module call_and_equality_exec (
    // clock and reset
    input  wire        clock,
    input  wire        rstn,
    // issue
    input  wire        instrValid,
    input  wire [31:0] instr,
    input  wire [31:0] pcIn,
    input  wire [31:0] firstSourceReg,
    input  wire [31:0] secondSourceReg,
    // program counter update
    output reg         pcLoad_r,
    output reg  [31:0] pcNext_r,
    // register write back
    output reg         regWrite_r,
    output reg  [4:0]  regWriteIdx_r,
    output reg  [31:0] regWriteData_r,
    // exception
    output reg         misalignedExc_r,
    output reg  [31:0] misalignedAddr_r
);
    // decoded instruction class
    wire        isCallImm;
    wire        isCallReg;
    wire        isCmpEq;

    call_cmp_decode call_cmp_decode_inst (
        .instr     (instr),
        .isCallImm (isCallImm),
        .isCallReg (isCallReg),
        .isCmpEq   (isCmpEq)
    );

    // instruction fields
    wire [25:0] jumpWordIndex;
    wire [4:0]  destReg;
    wire [3:0]  pcRegion;

    assign jumpWordIndex = instr[`WIDX_HI:`WIDX_LO];
    assign destReg       = instr[`DEST_HI:`DEST_LO];
    assign pcRegion      = pcIn[`PC_REGION_HI:`PC_REGION_LO];

    // address arithmetic
    wire [31:0] returnAddr;
    wire [31:0] immTarget;
    wire        regMisaligned;

    assign returnAddr    = pcIn + `NEXT_PC_STEP;
    // upper nibble kept, so the target cannot leave the 256-MB region
    assign immTarget     = {pcRegion, jumpWordIndex, 2'h0};
    assign regMisaligned = (firstSourceReg[1:0] != 2'h0);

    // per-bit match of the two operands
    wire [31:0] bitMatch;
    wire        equalFlag;

    genvar bitIdx;
    generate
        for (bitIdx = 0; bitIdx < 32; bitIdx = bitIdx + 1) begin : g_bitMatch
            assign bitMatch[bitIdx] = ~(firstSourceReg[bitIdx] ^ secondSourceReg[bitIdx]);
        end
    endgenerate

    // against the zero register this gives !first source
    assign equalFlag = &bitMatch;

    // accepted work this cycle
    wire        doCallImm;
    wire        doCallReg;
    wire        doCallRegOk;
    wire        doCallRegFault;
    wire        doCmpEq;

    assign doCallImm      = instrValid & isCallImm;
    assign doCallReg      = instrValid & isCallReg;
    assign doCallRegOk    = doCallReg & ~regMisaligned;
    assign doCallRegFault = doCallReg & regMisaligned;
    assign doCmpEq        = instrValid & isCmpEq;

    // one-hot operation kind
    localparam [4:0] KIND_IDLE       = 5'h01;
    localparam [4:0] KIND_CALL_IMM   = 5'h02;
    localparam [4:0] KIND_CALL_REG   = 5'h04;
    localparam [4:0] KIND_CALL_FAULT = 5'h08;
    localparam [4:0] KIND_CMP_EQ     = 5'h10;

    reg  [4:0]  opKind;

    always @* begin
        opKind = KIND_IDLE;
        if (doCallImm) begin
            opKind = KIND_CALL_IMM;
        end else if (doCallRegOk) begin
            opKind = KIND_CALL_REG;
        end else if (doCallRegFault) begin
            opKind = KIND_CALL_FAULT;
        end else if (doCmpEq) begin
            opKind = KIND_CMP_EQ;
        end
    end

    // program counter update
    reg         pcLoad_nxt;
    reg  [31:0] pcNext_nxt;

    always @* begin
        pcLoad_nxt = 1'h0;
        pcNext_nxt = pcNext_r;
        case (opKind)
            KIND_CALL_IMM: begin
                pcLoad_nxt = 1'h1;
                pcNext_nxt = immTarget;
            end
            KIND_CALL_REG: begin
                pcLoad_nxt = 1'h1;
                pcNext_nxt = firstSourceReg;
            end
            default: begin
                pcLoad_nxt = 1'h0;
                pcNext_nxt = pcNext_r;
            end
        endcase
    end

    // register write back
    reg         regWrite_nxt;
    reg  [4:0]  regWriteIdx_nxt;
    reg  [31:0] regWriteData_nxt;

    always @* begin
        regWrite_nxt     = 1'h0;
        regWriteIdx_nxt  = regWriteIdx_r;
        regWriteData_nxt = regWriteData_r;
        case (opKind)
            KIND_CALL_IMM: begin
                regWrite_nxt     = 1'h1;
                regWriteIdx_nxt  = `LINK_REG_IDX;
                regWriteData_nxt = returnAddr;
            end
            KIND_CALL_REG: begin
                regWrite_nxt     = 1'h1;
                regWriteIdx_nxt  = `LINK_REG_IDX;
                regWriteData_nxt = returnAddr;
            end
            KIND_CMP_EQ: begin
                regWrite_nxt     = 1'h1;
                regWriteIdx_nxt  = destReg;
                regWriteData_nxt = {31'h00000000, equalFlag};
            end
            default: begin
                regWrite_nxt     = 1'h0;
                regWriteIdx_nxt  = regWriteIdx_r;
                regWriteData_nxt = regWriteData_r;
            end
        endcase
    end

    // misaligned target fault
    reg         misalignedExc_nxt;
    reg  [31:0] misalignedAddr_nxt;

    always @* begin
        misalignedExc_nxt  = 1'h0;
        misalignedAddr_nxt = misalignedAddr_r;
        case (opKind)
            KIND_CALL_FAULT: begin
                // no pc or link update when the fault is taken
                misalignedExc_nxt  = 1'h1;
                misalignedAddr_nxt = firstSourceReg;
            end
            default: begin
                misalignedExc_nxt  = 1'h0;
                misalignedAddr_nxt = misalignedAddr_r;
            end
        endcase
    end

    // program counter registers
    always @(posedge clock) begin
        if (!rstn) begin
            pcLoad_r <= 1'h0;
            pcNext_r <= `PC_RESET_VALUE;
        end else begin
            pcLoad_r <= pcLoad_nxt;
            pcNext_r <= pcNext_nxt;
        end
    end

    // write-back registers
    always @(posedge clock) begin
        if (!rstn) begin
            regWrite_r     <= 1'h0;
            regWriteIdx_r  <= 5'h00;
            regWriteData_r <= 32'h00000000;
        end else begin
            regWrite_r     <= regWrite_nxt;
            regWriteIdx_r  <= regWriteIdx_nxt;
            regWriteData_r <= regWriteData_nxt;
        end
    end

    // fault registers
    always @(posedge clock) begin
        if (!rstn) begin
            misalignedExc_r  <= 1'h0;
            misalignedAddr_r <= 32'h00000000;
        end else begin
            misalignedExc_r  <= misalignedExc_nxt;
            misalignedAddr_r <= misalignedAddr_nxt;
        end
    end
endmodule

// ===== bench/call_cmp_monitor.sv
// Purpose: port assertions
// Assumes: one clock
// Notes: bound below
`timescale 1ns/1ps
module call_cmp_monitor (
    // clock and reset
    input wire        clock,
    input wire        rstn,
    // issue
    input wire        instrValid,
    input wire [31:0] instr,
    input wire [31:0] pcIn,
    input wire [31:0] firstSourceReg,
    input wire [31:0] secondSourceReg,
    // results
    input wire        pcLoad_r,
    input wire [31:0] pcNext_r,
    input wire        regWrite_r,
    input wire [4:0]  regWriteIdx_r,
    input wire [31:0] regWriteData_r,
    input wire        misalignedExc_r,
    input wire [31:0] misalignedAddr_r
);
    wire v = rstn & instrValid;
    wire ci = v & instr[5:0] == 6'h00;
    wire x = v & instr[5:0] == 6'h3A;
    wire cr = x & instr[26:6] == 21'h00FBA0;
    wire ce = x & instr[16:6] == 11'h400;
    wire cz = ce & instr[26:22] == 5'h00;
    wire cm = cr & firstSourceReg[1:0] != 2'h0;
    wire ok = ci | cr & !cm;
    wire bad = x & (instr[16:11] == 6'h1D & !cr | instr[16:11] == 6'h20 & !ce);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    property p_lnk; $past(ok) |-> regWriteIdx_r == 5'h1F & regWriteData_r == $past(pcIn) + 32'h4;
    endproperty
    a_lnk: assert property (p_lnk) else $error("link wrong");
    property p_tgt; $past(ci) |-> pcLoad_r & pcNext_r == {$past(pcIn[31:28]), $past(instr[31:6]), 2'h0};
    endproperty
    a_tgt: assert property (p_tgt) else $error("target wrong");
    property p_nof; $past(ci) |-> !misalignedExc_r; endproperty
    a_nof: assert property (p_nof) else $error("fault on call");
    property p_jmp; $past(cr & !cm) |-> pcLoad_r & pcNext_r == $past(firstSourceReg); endproperty
    a_jmp: assert property (p_jmp) else $error("jump wrong");
    property p_mis; $past(cm) |-> misalignedExc_r & !pcLoad_r & !regWrite_r
        & misalignedAddr_r == $past(firstSourceReg); endproperty
    a_mis: assert property (p_mis) else $error("fault wrong");
    property p_bad; $past(bad) |-> !(pcLoad_r | regWrite_r | misalignedExc_r); endproperty
    a_bad: assert property (p_bad) else $error("accepted bad word");
    property p_eq; $past(ce) |-> regWrite_r & regWriteIdx_r == $past(instr[21:17])
        & regWriteData_r == {31'h0, $past(firstSourceReg) == $past(secondSourceReg)}; endproperty
    a_eq: assert property (p_eq) else $error("compare wrong");
    property p_not; $past(cz) |-> regWriteData_r == {31'h0, $past(firstSourceReg) == 32'h0};
    endproperty
    a_not: assert property (p_not) else $error("negation wrong");
endmodule
bind call_and_equality_exec call_cmp_monitor call_cmp_monitor_inst (
    .clock            (clock),
    .rstn             (rstn),
    .instrValid       (instrValid),
    .instr            (instr),
    .pcIn             (pcIn),
    .firstSourceReg   (firstSourceReg),
    .secondSourceReg  (secondSourceReg),
    .pcLoad_r         (pcLoad_r),
    .pcNext_r         (pcNext_r),
    .regWrite_r       (regWrite_r),
    .regWriteIdx_r    (regWriteIdx_r),
    .regWriteData_r   (regWriteData_r),
    .misalignedExc_r  (misalignedExc_r),
    .misalignedAddr_r (misalignedAddr_r)
);

// ===== bench/tb_top.sv
// Purpose: directed bench
// Assumes: answer one cycle after taking edge
// Notes: monitor bound
`timescale 1ns/1ps
module tb_top;
    localparam CR = {5'h03, 5'h00, 5'h1F, 6'h1D, 5'h00, 6'h3A};
    localparam CE = {5'h04, 5'h05, 5'h09, 6'h20, 5'h00, 6'h3A};
    reg         clock = 1'h0, rstn = 1'h0, instrValid = 1'h0;
    reg  [31:0] instr = 32'h0, pcIn = 32'h0, firstSourceReg = 32'h0, secondSourceReg = 32'h0;
    wire        pcLoad_r, regWrite_r, misalignedExc_r;
    wire [31:0] pcNext_r, regWriteData_r, misalignedAddr_r;
    wire [4:0]  regWriteIdx_r;
    integer     err_total = 0, checked = 0, i;
    call_and_equality_exec call_and_equality_exec_inst (
        .clock            (clock),
        .rstn             (rstn),
        .instrValid       (instrValid),
        .instr            (instr),
        .pcIn             (pcIn),
        .firstSourceReg   (firstSourceReg),
        .secondSourceReg  (secondSourceReg),
        .pcLoad_r         (pcLoad_r),
        .pcNext_r         (pcNext_r),
        .regWrite_r       (regWrite_r),
        .regWriteIdx_r    (regWriteIdx_r),
        .regWriteData_r   (regWriteData_r),
        .misalignedExc_r  (misalignedExc_r),
        .misalignedAddr_r (misalignedAddr_r)
    );
    initial forever #25 clock = ~clock;
    task chk(input [31:0] got, exp);
        checked++;
        if (got !== exp) err_total++;
        if (got !== exp) $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    endtask
    // flags: pc load, reg write, fault
    task go(input [31:0] w, p, a, b, input [2:0] f);
        @(posedge clock) #1 instrValid = 1;
        {instr, pcIn, firstSourceReg, secondSourceReg} = {w, p, a, b};
        @(posedge clock) #1 instrValid = 0;
        chk({29'h0, pcLoad_r, regWrite_r, misalignedExc_r}, {29'h0, f});
    endtask
    task t_imm;
        go({26'h3FFFFFF, 6'h00}, 32'hF0000010, 32'h0, 32'h0, 3'h6);
        chk(pcNext_r, 32'hFFFFFFFC);
        chk({27'h0, regWriteIdx_r} ^ regWriteData_r, 32'hF000000B);
        $display("immediate call done");
    endtask
    task t_reg;
        go(CR, 32'h100, 32'h12345678, 32'h0, 3'h6);
        chk(pcNext_r, 32'h12345678);
        chk(regWriteData_r, 32'h00000104);
        for (i = 1; i < 4; i++) go(CR, 32'h200, 32'h12345678 + i, 32'h0, 3'h1);
        chk(misalignedAddr_r, 32'h1234567B);
        chk(pcNext_r, 32'h12345678);
        chk(regWriteData_r, 32'h00000104);
        go(CR ^ 32'h20000, 32'h300, 32'h8, 32'h0, 3'h0);
        $display("register call done");
    endtask
    task t_cmp;
        go(CE, 32'h0, 32'h7, 32'h7, 3'h2);
        chk({regWriteIdx_r, regWriteData_r[26:0]}, 32'h48000001);
        go(CE, 32'h0, 32'h7, 32'h6, 3'h2);
        chk(regWriteData_r, 32'h0);
        go(CE & 32'hF83FFFFF, 32'h0, 32'h0, 32'h0, 3'h2);
        chk(regWriteData_r, 32'h1);
        go(CE & 32'hF83FFFFF, 32'h0, 32'h5, 32'h0, 3'h2);
        chk(regWriteData_r, 32'h0);
        go(CE | 32'h40, 32'h0, 32'h1, 32'h1, 3'h0);
        $display("compare done");
    endtask
    // reset taken over a valid call clears every output
    task t_rst;
        @(posedge clock) #1 rstn = 1'h0;
        instrValid = 1'h1;
        {instr, pcIn} = {32'h00000040, 32'h00000100};
        @(posedge clock) #1 instrValid = 1'h0;
        chk({29'h0, pcLoad_r, regWrite_r, misalignedExc_r}, 32'h0);
        chk(pcNext_r, 32'h0);
        chk(regWriteData_r, 32'h0);
        chk(misalignedAddr_r, 32'h0);
        chk({27'h0, regWriteIdx_r}, 32'h0);
        rstn = 1'h1;
        $display("reset done");
    endtask
    task print_verdict;
        $display("checked %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clock);
        #1 rstn = 1;
        t_imm;
        t_reg;
        t_rst;
        t_cmp;
        print_verdict;
    end
    initial #20000 begin
        err_total++;
        print_verdict;
    end
endmodule
